/* File: core/i2cr_map.vh */
// register map, field positions, reset values and status codes of the two-wire controller
`ifndef I2CR_MAP_VH
`define I2CR_MAP_VH

// ==========================================================
// register byte addresses
`define I2CR_SET_ADDR 32'h40000000
`define I2CR_STAT_ADDR 32'h40000004
`define I2CR_DAT_ADDR 32'h40000008
`define I2CR_ADR0_ADDR 32'h4000000c
`define I2CR_HI_ADDR 32'h40000010
`define I2CR_LO_ADDR 32'h40000014
`define I2CR_CLR_ADDR 32'h40000018

// ==========================================================
// control flag bit positions (set and clear ports share them)
`define I2CR_AA_BIT 2
`define I2CR_SI_BIT 3
`define I2CR_STO_BIT 4
`define I2CR_STA_BIT 5
`define I2CR_EN_BIT 6
// general call enable sits in bit 0 of the own address
`define I2CR_GC_BIT 0

// ==========================================================
// reset values
`define I2CR_DAT_RST 8'h00
`define I2CR_ADR_RST 8'h00
`define I2CR_PHASE_RST 16'h0004

// ==========================================================
// status codes
`define I2CR_ST_IDLE 8'hf8
`define I2CR_ST_START 8'h08
`define I2CR_ST_RSTART 8'h10
`define I2CR_ST_MTA_ACK 8'h18
`define I2CR_ST_MTA_NAK 8'h20
`define I2CR_ST_MTD_ACK 8'h28
`define I2CR_ST_MTD_NAK 8'h30
`define I2CR_ST_MRA_ACK 8'h40
`define I2CR_ST_MRA_NAK 8'h48
`define I2CR_ST_MRD_ACK 8'h50
`define I2CR_ST_MRD_NAK 8'h58
`define I2CR_ST_SRA_OWN 8'h60
`define I2CR_ST_SRA_GC 8'h70
`define I2CR_ST_SRD_ACK 8'h80
`define I2CR_ST_SRD_NAK 8'h88
`define I2CR_ST_SLV_STOP 8'ha0
`define I2CR_ST_STA_OWN 8'ha8
`define I2CR_ST_STD_ACK 8'hb8
`define I2CR_ST_STD_NAK 8'hc0

`endif

/* File: core/i2cr_regs.v */
// two-wire bus controller: apb registers, byte shifter, address match and clock generator
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
// ==========================================================
// Summary of operation
// - shift byte buffer does not shift while irq pending is set; software writes land only then
// - bytes shift msb first; first received bit lands in bit 7
// - shift byte buffer is 8 bits, shared by transmit and receive, resets 0
// - own address is compared only in slave operation, ignored as master
// - own address bit 0 enables recognition of general call address 0x00
// - own address 0x00 means no address is ever acknowledged
// - own address clears to zero at reset, so slave recognition is off
// - own address holds the 7-bit slave address in bits 7:1
// - high phase count is 16 bits, resets to 4, sets scl high cycles
// - low phase count is 16 bits, resets to 4, sets scl low cycles
// - bit rate is pclk divided by high plus low phase counts plus two synchroniser cycles
// - high and low phase counts may differ for asymmetric duty cycle
// - writing one to a clear port bit clears its flag, except stop request at bit 4; zero does nothing
// - clear port bit 2 clears the ack assert flag
// - clear port bit 3 clears irq pending and releases the paused transfer
// - clear port bit 5 clears the begin condition request
// - clear port bit 6 clears iface on, disabling the interface
// - irq pending sets on every state change except idle; scl low is stretched
// - with iface off, inputs ignored, not addressed, stop flag forced 0
// - ack flag set drives ack low after address match or received byte
`include "i2cr_map.vh"

module i2cr_regs #(
  parameter CNT_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe
);

  // ==========================================================
  // engine states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_START = 2'b01;
  localparam [1:0] ST_XFER = 2'b10;
  localparam [1:0] ST_STOP = 2'b11;

  // ==========================================================
  // functions
  // a phase wait ends after lim cycles; a zero count ends at once
  function tick_done;
    input [CNT_W-1:0] c;
    input [CNT_W-1:0] lim;
    begin
      tick_done = ({1'b0, c} + 1'b1) >= {1'b0, lim};
    end
  endfunction

  // register addresses that answer without error
  function addr_ok;
    input [31:0] a;
    begin
      addr_ok = (a == `I2CR_SET_ADDR) || (a == `I2CR_STAT_ADDR) ||
        (a == `I2CR_DAT_ADDR) || (a == `I2CR_ADR0_ADDR) ||
        (a == `I2CR_HI_ADDR) || (a == `I2CR_LO_ADDR) ||
        (a == `I2CR_CLR_ADDR);
    end
  endfunction

  // status code reached at the end of a byte and its ack slot
  function [7:0] status_of;
    input m;
    input ap;
    input r;
    input nk;
    input g;
    begin
      if (m && ap)
        status_of = r ? (nk ? `I2CR_ST_MRA_NAK : `I2CR_ST_MRA_ACK)
                      : (nk ? `I2CR_ST_MTA_NAK : `I2CR_ST_MTA_ACK);
      else if (m)
        status_of = r ? (nk ? `I2CR_ST_MRD_NAK : `I2CR_ST_MRD_ACK)
                      : (nk ? `I2CR_ST_MTD_NAK : `I2CR_ST_MTD_ACK);
      else if (ap)
        status_of = g ? `I2CR_ST_SRA_GC : (r ? `I2CR_ST_STA_OWN : `I2CR_ST_SRA_OWN);
      else
        status_of = r ? (nk ? `I2CR_ST_STD_NAK : `I2CR_ST_STD_ACK)
                      : (nk ? `I2CR_ST_SRD_NAK : `I2CR_ST_SRD_ACK);
    end
  endfunction

  // ==========================================================
  // state
  reg [7:0] shift_byte_buffer;
  reg [7:0] own_address_0;
  reg [15:0] high_phase_count;
  reg [15:0] low_phase_count;
  reg ack_assert_flag;
  reg irq_pending_flag;
  reg stop_request;
  reg begin_condition_request;
  reg iface_on;
  reg [7:0] status;
  reg [1:0] state;
  reg [1:0] sub;
  reg [CNT_W-1:0] cnt;
  reg [3:0] bitcnt;
  reg mst;
  reg slv;
  reg addr_phase;
  reg tx;
  reg rd;
  reg nack;
  reg gc_seen;
  reg ack_drv;
  reg rstart;
  reg busy;
  reg scl_m;
  reg scl_s;
  reg scl_q;
  reg sda_m;
  reg sda_s;
  reg sda_q;
  reg [31:0] rd_val;

  // ==========================================================
  // apb strobes: a write lands at the access edge with pready high
  wire acc_wr = psel & penable & pready & pwrite;
  wire wr_set = acc_wr & (paddr == `I2CR_SET_ADDR);
  wire wr_dat = acc_wr & (paddr == `I2CR_DAT_ADDR);
  wire wr_adr = acc_wr & (paddr == `I2CR_ADR0_ADDR);
  wire wr_hi = acc_wr & (paddr == `I2CR_HI_ADDR);
  wire wr_lo = acc_wr & (paddr == `I2CR_LO_ADDR);
  wire wr_clr = acc_wr & (paddr == `I2CR_CLR_ADDR);

  // bus events seen on the synchronised lines only
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // address recognition; own address of zero never matches
  wire gc_hit = (shift_byte_buffer[7:1] == 7'h00) & own_address_0[`I2CR_GC_BIT];
  wire own_hit = (own_address_0[7:1] != 7'h00) &&
    (shift_byte_buffer[7:1] == own_address_0[7:1]);
  wire addr_hit = own_hit | gc_hit;

  // ==========================================================
  // read mux; reserved bits read as zero, the clear port reads zero
  always @* begin
    rd_val = 32'h00000000;
    case (paddr)
      `I2CR_SET_ADDR: begin
        rd_val[`I2CR_AA_BIT] = ack_assert_flag;
        rd_val[`I2CR_SI_BIT] = irq_pending_flag;
        rd_val[`I2CR_STO_BIT] = stop_request;
        rd_val[`I2CR_STA_BIT] = begin_condition_request;
        rd_val[`I2CR_EN_BIT] = iface_on;
      end
      `I2CR_STAT_ADDR: rd_val[7:0] = status;
      `I2CR_DAT_ADDR: rd_val[7:0] = shift_byte_buffer;
      `I2CR_ADR0_ADDR: rd_val[7:0] = own_address_0;
      `I2CR_HI_ADDR: rd_val[15:0] = high_phase_count;
      `I2CR_LO_ADDR: rd_val[15:0] = low_phase_count;
      default: rd_val = 32'h00000000;
    endcase
  end

  // ==========================================================
  // apb answer: data and error are captured in the setup cycle so
  // every answer leaves a flop; this costs no wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h00000000 : rd_val;
        pslverr <= ~addr_ok(paddr);
      end else begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================================
  // plain two-flop synchronisers; gating them on enable could fake a bus edge at turn-on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_m <= scl_in;
      sda_m <= sda_in;
      scl_s <= scl_m;
      sda_s <= sda_m;
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // ==========================================================
  // registers and byte engine; engine assignments come after the
  // software ones so a hardware set beats a same-cycle clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_byte_buffer <= `I2CR_DAT_RST;
      own_address_0 <= `I2CR_ADR_RST;
      high_phase_count <= `I2CR_PHASE_RST;
      low_phase_count <= `I2CR_PHASE_RST;
      ack_assert_flag <= 1'b0;
      irq_pending_flag <= 1'b0;
      stop_request <= 1'b0;
      begin_condition_request <= 1'b0;
      iface_on <= 1'b0;
      status <= `I2CR_ST_IDLE;
      state <= ST_IDLE;
      sub <= 2'b00;
      cnt <= {CNT_W{1'b0}};
      bitcnt <= 4'h0;
      mst <= 1'b0;
      slv <= 1'b0;
      addr_phase <= 1'b0;
      tx <= 1'b0;
      rd <= 1'b0;
      nack <= 1'b0;
      gc_seen <= 1'b0;
      ack_drv <= 1'b0;
      rstart <= 1'b0;
      busy <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      // open-drain lines only ever pull low
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      // set port: ones set flags, zeros do nothing
      if (wr_set) begin
        if (pwdata[`I2CR_AA_BIT]) ack_assert_flag <= 1'b1;
        if (pwdata[`I2CR_SI_BIT]) irq_pending_flag <= 1'b1;
        if (pwdata[`I2CR_STO_BIT]) stop_request <= 1'b1;
        if (pwdata[`I2CR_STA_BIT]) begin_condition_request <= 1'b1;
        if (pwdata[`I2CR_EN_BIT]) iface_on <= 1'b1;
      end
      // clear port; reserved bit positions have no effect
      if (wr_clr) begin
        if (pwdata[`I2CR_AA_BIT]) ack_assert_flag <= 1'b0;
        if (pwdata[`I2CR_SI_BIT]) irq_pending_flag <= 1'b0;
        if (pwdata[`I2CR_STA_BIT]) begin_condition_request <= 1'b0;
        if (pwdata[`I2CR_EN_BIT]) iface_on <= 1'b0;
      end
      // buffer writes only while paused, never mid-byte
      if (wr_dat && irq_pending_flag)
        shift_byte_buffer <= pwdata[7:0];
      if (wr_adr)
        own_address_0 <= pwdata[7:0];
      if (wr_hi)
        high_phase_count <= pwdata[15:0];
      if (wr_lo)
        low_phase_count <= pwdata[15:0];
      // bus busy between any start and stop
      if (start_det)
        busy <= 1'b1;
      else if (stop_det)
        busy <= 1'b0;

      if (!iface_on) begin
        // disabled: drop all bus state and release both lines
        state <= ST_IDLE;
        mst <= 1'b0;
        slv <= 1'b0;
        busy <= 1'b0;
        stop_request <= 1'b0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        status <= `I2CR_ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            cnt <= {CNT_W{1'b0}};
            // a stop request in slave mode only recovers; nothing is sent
            if (stop_request && !begin_condition_request)
              stop_request <= 1'b0;
            if (start_det) begin
              state <= ST_XFER;
              bitcnt <= 4'h0;
              addr_phase <= 1'b1;
              tx <= 1'b0;
              slv <= 1'b0;
              mst <= 1'b0;
            end else if (begin_condition_request && !busy) begin
              state <= ST_START;
              sub <= 2'b01;
              mst <= 1'b1;
              rstart <= 1'b0;
            end
          end
          ST_START: begin
            case (sub)
              2'b00: begin
                // repeated start: release data while clock is held low
                sda_oe <= 1'b0;
                scl_oe <= 1'b1;
                if (tick_done(cnt, low_phase_count[CNT_W-1:0])) begin
                  cnt <= {CNT_W{1'b0}};
                  sub <= 2'b01;
                end else begin
                  cnt <= cnt + 1'b1;
                end
              end
              2'b01: begin
                // count the high phase only once the line really is high
                scl_oe <= 1'b0;
                if (scl_s) begin
                  if (tick_done(cnt, high_phase_count[CNT_W-1:0])) begin
                    cnt <= {CNT_W{1'b0}};
                    sub <= 2'b10;
                  end else begin
                    cnt <= cnt + 1'b1;
                  end
                end
              end
              2'b10: begin
                sda_oe <= 1'b1;
                if (tick_done(cnt, high_phase_count[CNT_W-1:0])) begin
                  cnt <= {CNT_W{1'b0}};
                  sub <= 2'b11;
                end else begin
                  cnt <= cnt + 1'b1;
                end
              end
              default: begin
                // start done: pause with clock low for the address byte
                scl_oe <= 1'b1;
                irq_pending_flag <= 1'b1;
                status <= rstart ? `I2CR_ST_RSTART : `I2CR_ST_START;
                state <= ST_XFER;
                bitcnt <= 4'h0;
                addr_phase <= 1'b1;
                tx <= 1'b1;
                cnt <= {CNT_W{1'b0}};
              end
            endcase
          end
          ST_XFER: begin
            if (!mst && stop_det) begin
              // stop from the far master ends any slave transfer
              state <= ST_IDLE;
              scl_oe <= 1'b0;
              sda_oe <= 1'b0;
              slv <= 1'b0;
              if (slv) begin
                irq_pending_flag <= 1'b1;
                status <= `I2CR_ST_SLV_STOP;
              end
            end else if (!mst && start_det) begin
              // repeated start from the far master restarts addressing
              bitcnt <= 4'h0;
              addr_phase <= 1'b1;
              tx <= 1'b0;
              slv <= 1'b0;
              sda_oe <= 1'b0;
              if (slv) begin
                irq_pending_flag <= 1'b1;
                status <= `I2CR_ST_SLV_STOP;
              end
            end else if (mst && !irq_pending_flag && bitcnt == 4'h0 && scl_oe &&
                         (stop_request || (begin_condition_request && !addr_phase))) begin
              cnt <= {CNT_W{1'b0}};
              if (stop_request) begin
                state <= ST_STOP;
                sub <= 2'b00;
              end else begin
                state <= ST_START;
                sub <= 2'b00;
                rstart <= 1'b1;
              end
            end else begin
              // clock: master divides pclk, slave only stretches
              if (mst) begin
                if (scl_oe) begin
                  // low phase frozen while paused
                  if (!irq_pending_flag) begin
                    if (tick_done(cnt, low_phase_count[CNT_W-1:0])) begin
                      cnt <= {CNT_W{1'b0}};
                      scl_oe <= 1'b0;
                    end else begin
                      cnt <= cnt + 1'b1;
                    end
                  end
                end else if (scl_s) begin
                  // a stretching slave delays this count
                  if (tick_done(cnt, high_phase_count[CNT_W-1:0])) begin
                    cnt <= {CNT_W{1'b0}};
                    scl_oe <= 1'b1;
                  end else begin
                    cnt <= cnt + 1'b1;
                  end
                end
              end else begin
                scl_oe <= irq_pending_flag & (scl_oe | ~scl_s);
              end
              // sample on rising clock; shifting stops while paused
              if (scl_rise && !irq_pending_flag) begin
                if (bitcnt < 4'h8) begin
                  shift_byte_buffer <= {shift_byte_buffer[6:0], sda_s};
                  bitcnt <= bitcnt + 4'h1;
                end else begin
                  nack <= sda_s;
                  bitcnt <= 4'h9;
                end
              end
              // falling clock opens the ack slot or closes the byte
              if (scl_fall && bitcnt == 4'h8) begin
                if (addr_phase && !mst) begin
                  if (addr_hit && ack_assert_flag) begin
                    slv <= 1'b1;
                    ack_drv <= 1'b1;
                    rd <= shift_byte_buffer[0];
                    gc_seen <= gc_hit;
                  end else begin
                    // not addressed: step off the bus
                    state <= ST_IDLE;
                    ack_drv <= 1'b0;
                    sda_oe <= 1'b0;
                    scl_oe <= 1'b0;
                  end
                end else if (addr_phase) begin
                  rd <= shift_byte_buffer[0];
                  ack_drv <= 1'b0;
                end else begin
                  ack_drv <= ~tx & ack_assert_flag;
                end
              end
              if (scl_fall && bitcnt == 4'h9) begin
                bitcnt <= 4'h0;
                irq_pending_flag <= 1'b1;
                status <= status_of(mst, addr_phase, rd, nack, gc_seen);
                addr_phase <= 1'b0;
                ack_drv <= 1'b0;
                tx <= mst ? ~rd : rd;
              end
              // data changes only while the clock is low
              if (!scl_s) begin
                if (bitcnt == 4'h8)
                  sda_oe <= ack_drv;
                else
                  sda_oe <= tx & (bitcnt < 4'h8) & ~shift_byte_buffer[7];
              end
            end
          end
          default: begin
            case (sub)
              2'b00: begin
                // stop: pull data low under a low clock
                scl_oe <= 1'b1;
                sda_oe <= 1'b1;
                if (tick_done(cnt, low_phase_count[CNT_W-1:0])) begin
                  cnt <= {CNT_W{1'b0}};
                  sub <= 2'b01;
                end else begin
                  cnt <= cnt + 1'b1;
                end
              end
              2'b01: begin
                scl_oe <= 1'b0;
                if (scl_s) begin
                  if (tick_done(cnt, high_phase_count[CNT_W-1:0])) begin
                    cnt <= {CNT_W{1'b0}};
                    sub <= 2'b10;
                  end else begin
                    cnt <= cnt + 1'b1;
                  end
                end
              end
              default: begin
                // entering idle raises no interrupt
                sda_oe <= 1'b0;
                stop_request <= 1'b0;
                mst <= 1'b0;
                status <= `I2CR_ST_IDLE;
                state <= ST_IDLE;
              end
            endcase
          end
        endcase
      end
    end
  end

endmodule

/* File: bench/i2cr_checker.sv */
// concurrent checks on the apb and bus pins of the two-wire register block
`timescale 1ns/1ns
`include "i2cr_map.vh"
// ==========================================================
// pin checker
module i2cr_checker #(
  parameter CNT_W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus phases that the checks start from
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd(a);
    pready && !pwrite && paddr == a;
  endsequence
  sequence s_off;
    pready && pwrite && paddr == `I2CR_CLR_ADDR && pwdata[6];
  endsequence
  a_ready_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_decode: assert property (pready |-> pslverr == (paddr > `I2CR_CLR_ADDR
    || paddr < `I2CR_SET_ADDR || paddr[1:0] != 2'b00)) else $error("bad error flag");
  a_rdata_quiet: assert property (!pready || pwrite |-> prdata == 32'h0)
    else $error("read data outside read");
  a_dat_width: assert property (s_rd(`I2CR_DAT_ADDR) |-> prdata[31:8] == 24'h0)
    else $error("byte buffer wide");
  a_adr_width: assert property (s_rd(`I2CR_ADR0_ADDR) |-> prdata[31:8] == 24'h0)
    else $error("own address wide");
  a_phase_width: assert property (s_rd(`I2CR_HI_ADDR) or s_rd(`I2CR_LO_ADDR) |->
    prdata[31:16] == 16'h0) else $error("phase count wide");
  a_off_release: assert property (s_off |-> ##[1:8] !scl_oe && !sda_oe)
    else $error("lines held when off");
  a_low_min: assert property ($rose(scl_oe) |-> scl_oe[*4])
    else $error("clock low too short");
  a_high_min: assert property ($fell(scl_oe) |-> !scl_oe[*4])
    else $error("clock high too short");
  a_pins_low: assert property (!scl_out && !sda_out)
    else $error("open drain data not low");
endmodule

bind i2cr_regs i2cr_checker #(.CNT_W(CNT_W)) u_i2cr_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

/* File: bench/i2cr_peer.sv */
// far-side target that acks one address and keeps the first two bytes it hears
`timescale 1ns/1ns
// ==========================================================
// far-side target
module i2cr_peer #(
  parameter [6:0] ADDR = 7'h2a
) (
  input wire scl,
  input wire sda,
  output reg pull
);
  reg [7:0] sh = 8'h00;
  reg [7:0] rx [0:1];
  integer bits = 0;
  integer n = 0;
  reg act = 0;
  initial pull = 0;
  // start arms the receiver, stop disarms it
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1;
    bits = 0;
    n = 0;
  end
  always @(posedge sda) if (scl === 1'b1) act = 0;
  // bits are taken on the rising clock
  always @(posedge scl) if (act) begin
    sh = {sh[6:0], sda};
    bits = bits + 1;
  end
  // ack slot: the address byte only for its own address, so a wrong address reads back as a nack; every later byte always
  always @(negedge scl) if (act && bits == 8) begin
    if (n < 2) rx[n] = sh;
    n = n + 1;
    pull = (n > 1) || (sh[7:1] == ADDR);
  end else if (bits == 9) begin
    pull = 0;
    bits = 0;
  end
endmodule

/* File: bench/tb_top.sv */
// self-checking bench for the two-wire register block
`timescale 1ns/1ns
`include "i2cr_map.vh"
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, g, w); end end
// ==========================================================
// bench
module tb_top;
  typedef struct packed {logic [31:0] e; logic [31:0] m; logic er;} i2cr_note_t;
  reg pclk = 0;
  reg presetn = 0;
  reg psel = 0;
  reg penable = 0;
  reg pwrite = 0;
  reg [31:0] paddr = 0;
  reg [31:0] pwdata = 0;
  wire [31:0] prdata;
  wire pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, pull;
  wire scl = ~scl_oe;
  wire sda = ~(sda_oe | pull);
  i2cr_note_t q[$];
  i2cr_note_t nt;
  integer n_fail = 0, checks_done = 0, per = 0, p1;
  time last = 0;
  reg [7:0] rnd = 8'h5f;
  reg [7:0] d;
  reg [31:0] rd;
  i2cr_regs #(.CNT_W(16)) u_i2cr_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  i2cr_peer u_i2cr_peer (.scl(scl), .sda(sda), .pull(pull));
  always #20 pclk = ~pclk;
  function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // bit time in clocks between rises of the wired clock line
  always @(posedge scl) begin
    per = ($time - last) / 40;
    last = $time;
  end
  // every completed access is matched against the oldest note
  always @(posedge pclk) if (psel && penable && pready) begin
    nt = q.pop_front();
    `CHK(prdata & nt.m, nt.e & nt.m)
    `CHK(pslverr, nt.er)
  end
  task results;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // one apb transfer; request held until ready is seen at an edge
  task apb(input [31:0] a, input w, input [31:0] v, input [31:0] e, input [31:0] m);
    integer k;
    begin
      q.push_back({e, m, a > `I2CR_CLR_ADDR});
      psel <= 1;
      penable <= 0;
      paddr <= a;
      pwrite <= w;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (pready !== 1'b1 && k < 8);
      rd = prdata;
      if (pready !== 1'b1) begin n_fail++; results; end
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task wr(input [31:0] a, input [31:0] v);
    apb(a, 1'b1, v, 32'h0, 32'hffffffff);
  endtask
  task rdc(input [31:0] a, input [31:0] e);
    apb(a, 1'b0, 32'h0, e, 32'hffffffff);
  endtask
  task clr_chk(input [31:0] c, input [31:0] e);
    begin
      wr(`I2CR_CLR_ADDR, c);
      rdc(`I2CR_SET_ADDR, e);
    end
  endtask
  // polls status under a bound, then takes one checked read
  task wait_st(input [7:0] s);
    integer j;
    begin
      j = 0;
      do begin
        apb(`I2CR_STAT_ADDR, 1'b0, 32'h0, 32'h0, 32'h0);
        j++;
      end while (rd[7:0] !== s && j < 300);
      if (rd[7:0] !== s) begin n_fail++; results; end
      rdc(`I2CR_STAT_ADDR, {24'h0, s});
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdc(`I2CR_DAT_ADDR, 32'h0);
    rdc(`I2CR_ADR0_ADDR, 32'h0);
    rdc(`I2CR_HI_ADDR, 32'h4);
    rdc(`I2CR_LO_ADDR, 32'h4);
    rdc(`I2CR_STAT_ADDR, 32'hf8);
    rdc(`I2CR_SET_ADDR, 32'h0);
    $display("test reset done");
    rnd = lfsr(rnd);
    wr(`I2CR_ADR0_ADDR, {24'hffffff, rnd});
    rdc(`I2CR_ADR0_ADDR, {24'h0, rnd});
    wr(`I2CR_HI_ADDR, 32'hffff0007);
    rdc(`I2CR_HI_ADDR, 32'h7);
    wr(`I2CR_LO_ADDR, 32'h6);
    rdc(`I2CR_LO_ADDR, 32'h6);
    apb(32'h4000001c, 1'b0, 32'h0, 32'h0, 32'h0);
    wr(`I2CR_DAT_ADDR, 32'ha5);
    rdc(`I2CR_DAT_ADDR, 32'h0);
    $display("test regs done");
    wr(`I2CR_SET_ADDR, 32'h24);
    clr_chk(32'h00, 32'h24);
    clr_chk(32'h04, 32'h20);
    clr_chk(32'h20, 32'h00);
    wr(`I2CR_SET_ADDR, 32'h40);
    clr_chk(32'h40, 32'h00);
    $display("test clear done");
    // master write: address then one random byte, low phase widened in between
    wr(`I2CR_SET_ADDR, 32'h60);
    wait_st(8'h08);
    wr(`I2CR_DAT_ADDR, 32'h54);
    rdc(`I2CR_DAT_ADDR, 32'h54);
    wr(`I2CR_CLR_ADDR, 32'h28);
    wait_st(8'h18);
    p1 = per;
    `CHK(scl, 1'b0)
    rnd = lfsr(rnd);
    d = rnd;
    wr(`I2CR_LO_ADDR, 32'ha);
    wr(`I2CR_DAT_ADDR, {24'h0, d});
    wr(`I2CR_CLR_ADDR, 32'h08);
    wait_st(8'h28);
    `CHK(per - p1, 4)
    `CHK(u_i2cr_peer.rx[0], 8'h54)
    `CHK(u_i2cr_peer.rx[1], d)
    wr(`I2CR_SET_ADDR, 32'h10);
    wr(`I2CR_CLR_ADDR, 32'h08);
    wait_st(8'hf8);
    wr(`I2CR_CLR_ADDR, 32'h40);
    $display("test master done");
    results;
  end
endmodule
